// ===== hw/wcm_top.sv
// Purpose: Command registers and mode decode for a dual-loop WAN clock synthesizer
// Assumes: Loop lock levels and master select are synchronous to pclk
// Notes:   Zero-wait APB slave; read data is captured in the setup phase
`timescale 1ns/10ps
`default_nettype none

// Function
// - Register 0x10 holds frame, first-clock, second-clock enables in bits 4..2, lock select in 1..0.
// - Lock select 00 ANDs all enabled loops, 01 follows loop two, 10 loop one, 11 forces low.
// - Reverse mode takes a 56 or 64 kHz reference and yields 1.544 or 2.048 MHz outputs.
// - Code 0011 selects 56 kHz, 0111 selects 64 kHz; loop one gives 1.544 MHz, loop two 2.048 MHz.
// - Register 0x00 holds the mode code in bits 4..1 and loop-one enable in bit 0, gating clock one.
// - Bit 0 of the reference-multiplier register enables loop two and gates clock two.
// - Reverse mode ignores reference-multiplier bits 4..1 and both output-multiplier registers.
// - Fractional reverse mode takes a multiple of 56 or 64 kHz and yields 1.544 or 2.048 MHz.
// - With a 56 kHz multiple, code 1001 gives 1.544/2.048 MHz and 1010 gives 1.544 on both.
// - With a 64 kHz multiple, code 1011 gives 2.048/1.544 MHz and 1100 gives 2.048 on both.
// - The first-output multiplier register holds the first-clock multiplier minus one.
// - In forward mode reference-multiplier bits 4..1 hold the reference multiple minus one.
module wcm_top #(
    parameter int ADDR_W = 8                   // APB address width
) (
    input  wire logic              pclk,           // APB clock, 250 MHz
    input  wire logic              presetn,        // Async reset, active low
    input  wire logic              psel,           // APB select
    input  wire logic              penable,        // APB access phase
    input  wire logic              pwrite,         // APB direction
    input  wire logic [ADDR_W-1:0] paddr,          // APB byte address
    input  wire logic [31:0]       pwdata,         // APB write data
    output logic                   pready,         // APB ready
    output logic      [31:0]       prdata,         // APB read data
    output logic                   pslverr,        // APB error on unmapped access
    input  wire logic              loop1_locked,   // First loop lock level
    input  wire logic              loop2_locked,   // Second loop lock level
    input  wire logic              master_select,  // Cascade master strap level
    output logic                   loop1_run,      // First loop enabled
    output logic                   loop2_run,      // Second loop enabled
    output logic                   first_clock_output_out_en,    // Drive first clock output
    output logic                   second_clock_output_out_en,    // Drive second clock output
    output logic                   frame_out_en,   // Drive frame marker output
    output logic      [1:0]        mode_class,     // Decoded conversion class
    output logic                   ref_hi,         // Reference family: 64k or E1
    output logic                   loop1_hi,       // Loop one family: 2.048M or 64k
    output logic                   loop2_hi,       // Loop two family: 2.048M or 64k
    output logic      [3:0]        ref_mult,       // Reference multiple minus one
    output logic      [4:0]        out1_mult,      // First output multiplier minus one
    output logic      [4:0]        out2_mult,      // Second output multiplier minus one
    output logic                   lock_indicator, // Selected lock output
    output logic                   irq             // Level interrupt
);
    // The unmapped test slices paddr above bit 4, so bit 5 must exist
    if (ADDR_W < 6) begin : g_addr_w_chk
        $error("ADDR_W must be at least 6");
    end

    logic [4:0] mode_ff, refm_ff, out1_ff, out2_ff, outen_ff;
    logic [2:0] stat_ff, mask_ff;
    logic       lock_ff, rsvd_prev_ff;
    logic [31:0] prdata_ff;
    logic       run1_ff, run2_ff, c1_ff, c2_ff, fr_ff, rhi_ff, l1hi_ff, l2hi_ff;
    logic [1:0] cls_ff;
    logic [3:0] refmul_ff;
    logic [4:0] o1_ff, o2_ff;

    // APB decode; indices beyond seven or misaligned addresses are unmapped
    wire [2:0] idx      = paddr[4:2];
    wire       mapped   = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
    wire       setup    = psel && !penable;
    wire       access   = psel && penable;
    wire       wr_go    = access && pwrite && mapped;
    wire [4:0] wd       = pwdata[4:0];
    wire       wr_mode  = wr_go && (idx == wcm_pkg::IDX_MODE);
    wire       wr_refm  = wr_go && (idx == wcm_pkg::IDX_REFMUL);
    wire       wr_out1  = wr_go && (idx == wcm_pkg::IDX_OUT1);
    wire       wr_out2  = wr_go && (idx == wcm_pkg::IDX_OUT2);
    wire       wr_outen = wr_go && (idx == wcm_pkg::IDX_OUTEN);
    wire       wr_stat  = wr_go && (idx == wcm_pkg::IDX_IRQSTAT);
    wire       wr_mask  = wr_go && (idx == wcm_pkg::IDX_IRQMASK);

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_ff;

    // Mode decode: class and frequency families per code
    wire [3:0] code = mode_ff[4:1];
    wcm_pkg::wcm_class_t cls;
    logic rhi, l1hi, l2hi;
    always_comb begin
        cls  = wcm_pkg::WCM_RSVD;
        rhi  = 1'b0;
        l1hi = 1'b0;
        l2hi = 1'b0;
        unique case (code)
            wcm_pkg::MC_F_T1_5656: cls = wcm_pkg::WCM_FWD;
            wcm_pkg::MC_F_T1_5664: begin
                cls  = wcm_pkg::WCM_FWD;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_F_T1_6464: begin
                cls  = wcm_pkg::WCM_FWD;
                l1hi = 1'b1;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_F_E1_5656: begin
                cls = wcm_pkg::WCM_FWD;
                rhi = 1'b1;
            end
            wcm_pkg::MC_F_E1_5664: begin
                cls  = wcm_pkg::WCM_FWD;
                rhi  = 1'b1;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_F_E1_6464: begin
                cls  = wcm_pkg::WCM_FWD;
                rhi  = 1'b1;
                l1hi = 1'b1;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_R_56K: begin
                cls  = wcm_pkg::WCM_REV;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_R_64K: begin
                cls  = wcm_pkg::WCM_REV;
                rhi  = 1'b1;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_FR_56_T1E1: begin
                cls  = wcm_pkg::WCM_FRAC;
                l2hi = 1'b1;
            end
            wcm_pkg::MC_FR_56_T1T1: cls = wcm_pkg::WCM_FRAC;
            wcm_pkg::MC_FR_64_E1T1: begin
                cls  = wcm_pkg::WCM_FRAC;
                rhi  = 1'b1;
                l1hi = 1'b1;
            end
            wcm_pkg::MC_FR_64_E1E1: begin
                cls  = wcm_pkg::WCM_FRAC;
                rhi  = 1'b1;
                l1hi = 1'b1;
                l2hi = 1'b1;
            end
            default: cls = wcm_pkg::WCM_RSVD;
        endcase
    end

    // Loop and output gating; a reserved code stops both loops
    wire rsvd     = (cls == wcm_pkg::WCM_RSVD);
    wire rev      = (cls == wcm_pkg::WCM_REV);
    wire nxt_run1 = mode_ff[wcm_pkg::LOOP_EN_BIT] && !rsvd;
    wire nxt_run2 = refm_ff[wcm_pkg::LOOP_EN_BIT] && !rsvd;
    wire nxt_c1   = nxt_run1 && outen_ff[wcm_pkg::FIRST_CLOCK_OUTPUT_EN_BIT];
    wire nxt_c2   = nxt_run2 && outen_ff[wcm_pkg::SECOND_CLOCK_OUTPUT_EN_BIT];
    wire nxt_fr   = outen_ff[wcm_pkg::FRAME_EN_BIT] && !rsvd;

    // Reverse mode hides the multipliers so stale values never steer the loops
    wire [3:0] nxt_refmul = rev ? 4'h0 : refm_ff[4:1];
    wire [4:0] nxt_o1     = rev ? 5'h00 : out1_ff;
    wire [4:0] nxt_o2     = rev ? 5'h00 : out2_ff;

    // Lock indicator selection
    wire [1:0] lsel     = outen_ff[wcm_pkg::LOCK_SEL_HI:wcm_pkg::LOCK_SEL_LO];
    wire       any_run  = nxt_run1 || nxt_run2;
    wire       all_lock = any_run && (!nxt_run1 || loop1_locked)
                                  && (!nxt_run2 || loop2_locked);
    logic nxt_lock;
    always_comb begin
        unique case (lsel)
            wcm_pkg::LOCK_ALL:   nxt_lock = all_lock;
            wcm_pkg::LOCK_LOOP2: nxt_lock = loop2_locked;
            wcm_pkg::LOCK_LOOP1: nxt_lock = loop1_locked;
            wcm_pkg::LOCK_OFF:   nxt_lock = 1'b0;
        endcase
    end

    // Events: lock edges and entry into a reserved code; set wins over clear
    wire [2:0] evt;
    assign evt[wcm_pkg::EVT_LOCK_GAIN] = nxt_lock && !lock_ff;
    assign evt[wcm_pkg::EVT_LOCK_LOSS] = !nxt_lock && lock_ff;
    assign evt[wcm_pkg::EVT_RSVD_MODE] = rsvd && !rsvd_prev_ff;
    wire [2:0] nxt_stat = (stat_ff & ~(wr_stat ? wd[2:0] : 3'h0)) | evt;

    // Read mux; master select shown so software can confirm the strap
    logic [4:0] rd;
    always_comb begin
        unique case (idx)
            wcm_pkg::IDX_MODE:    rd = mode_ff;
            wcm_pkg::IDX_REFMUL:  rd = refm_ff;
            wcm_pkg::IDX_OUT1:    rd = out1_ff;
            wcm_pkg::IDX_OUT2:    rd = out2_ff;
            wcm_pkg::IDX_OUTEN:   rd = outen_ff;
            wcm_pkg::IDX_IRQSTAT: rd = {2'h0, stat_ff};
            wcm_pkg::IDX_IRQMASK: rd = {2'h0, mask_ff};
            wcm_pkg::IDX_STATUS:  rd = {master_select, loop2_locked, loop1_locked,
                                        lock_ff, rsvd};
        endcase
    end
    wire [31:0] nxt_prdata = (setup && !pwrite && mapped) ? {27'h000_0000, rd} : prdata_ff;

    // Command and interrupt registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff  <= wcm_pkg::CMD_RESET;
            refm_ff  <= wcm_pkg::CMD_RESET;
            out1_ff  <= wcm_pkg::CMD_RESET;
            out2_ff  <= wcm_pkg::CMD_RESET;
            outen_ff <= wcm_pkg::CMD_RESET;
            stat_ff  <= 3'h0;
            mask_ff  <= 3'h0;
        end else begin
            if (wr_mode)  mode_ff  <= wd;
            if (wr_refm)  refm_ff  <= wd;
            if (wr_out1)  out1_ff  <= wd;
            if (wr_out2)  out2_ff  <= wd;
            if (wr_outen) outen_ff <= wd;
            if (wr_mask)  mask_ff  <= wd[2:0];
            stat_ff <= nxt_stat;
        end
    end

    // Registered outputs toward the loops and pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {run1_ff, run2_ff, c1_ff, c2_ff, fr_ff} <= 5'h00;
            {rhi_ff, l1hi_ff, l2hi_ff, lock_ff}     <= 4'h0;
            rsvd_prev_ff <= 1'b0;
            cls_ff       <= wcm_pkg::WCM_FWD;
            refmul_ff    <= 4'h0;
            o1_ff        <= 5'h00;
            o2_ff        <= 5'h00;
            prdata_ff    <= 32'h0000_0000;
        end else begin
            {run1_ff, run2_ff, c1_ff, c2_ff, fr_ff} <= {nxt_run1, nxt_run2, nxt_c1, nxt_c2, nxt_fr};
            {rhi_ff, l1hi_ff, l2hi_ff, lock_ff}     <= {rhi, l1hi, l2hi, nxt_lock};
            rsvd_prev_ff <= rsvd;
            cls_ff       <= cls;
            refmul_ff    <= nxt_refmul;
            o1_ff        <= nxt_o1;
            o2_ff        <= nxt_o2;
            prdata_ff    <= nxt_prdata;
        end
    end

    assign loop1_run      = run1_ff;
    assign loop2_run      = run2_ff;
    assign first_clock_output_out_en    = c1_ff;
    assign second_clock_output_out_en    = c2_ff;
    assign frame_out_en   = fr_ff;
    assign mode_class     = cls_ff;
    assign ref_hi         = rhi_ff;
    assign loop1_hi       = l1hi_ff;
    assign loop2_hi       = l2hi_ff;
    assign ref_mult       = refmul_ff;
    assign out1_mult      = o1_ff;
    assign out2_mult      = o2_ff;
    assign lock_indicator = lock_ff;
    assign irq            = |(stat_ff & mask_ff);

    // Checks on the decoded outputs
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_rsvd_clk_off: assert property (rsvd |=> !first_clock_output_out_en && !second_clock_output_out_en)
        else $error("clock output on under reserved code");
    a_first_clock_output_gate: assert property (first_clock_output_out_en |-> $past(mode_ff[0]) && $past(outen_ff[3]))
        else $error("clock one on without both enables");
    a_second_clock_output_gate: assert property (second_clock_output_out_en |-> $past(refm_ff[0]) && $past(outen_ff[2]))
        else $error("clock two on without both enables");
    a_lock_forced: assert property (lsel == wcm_pkg::LOCK_OFF |=> !lock_indicator)
        else $error("lock indicator high while forced low");
    a_lock_loop1: assert property (lsel == wcm_pkg::LOCK_LOOP1 |=>
                                   lock_indicator == $past(loop1_locked))
        else $error("lock indicator does not follow loop one");
    a_rev_ignore: assert property (mode_class == 2'b01 |->
                                   ref_mult == 4'h0 && out1_mult == 5'h00 && out2_mult == 5'h00)
        else $error("multipliers visible in reverse mode");
    a_rev_freq: assert property (code == wcm_pkg::MC_R_64K |=>
                                 mode_class == 2'b01 && ref_hi && !loop1_hi && loop2_hi)
        else $error("reverse 64k code decoded wrongly");
    a_frac_freq: assert property (code == wcm_pkg::MC_FR_56_T1T1 |=>
                                  mode_class == 2'b10 && !loop1_hi && !loop2_hi && !ref_hi)
        else $error("fractional 1010 code decoded wrongly");
    a_frac64_freq: assert property (code == wcm_pkg::MC_FR_64_E1T1 |=>
                                    loop1_hi && !loop2_hi && ref_hi)
        else $error("fractional 1011 code decoded wrongly");
    a_out2_pass: assert property (mode_class != 2'b01 |-> out2_mult == $past(out2_ff))
        else $error("second multiplier not passed outside reverse mode");
    a_lock_loop2: assert property (lsel == wcm_pkg::LOCK_LOOP2 |=>
                                   lock_indicator == $past(loop2_locked))
        else $error("lock indicator does not follow loop two");
    a_frame_gate: assert property (frame_out_en |-> $past(outen_ff[4]) && !$past(rsvd))
        else $error("frame output on without its enable");
    a_rev56_freq: assert property (code == wcm_pkg::MC_R_56K |=>
                                   mode_class == 2'b01 && !ref_hi && !loop1_hi && loop2_hi)
        else $error("reverse 56k code decoded wrongly");

    c_rev_first_clock_output: cover property (code == wcm_pkg::MC_R_56K ##1 first_clock_output_out_en);
    c_frac_both: cover property (mode_class == 2'b10 && first_clock_output_out_en && second_clock_output_out_en);
    c_loss_irq: cover property (lock_indicator ##1 !lock_indicator ##1 irq);
endmodule : wcm_top

`default_nettype wire

// ===== hw/wcm_pkg.sv
// Purpose: Shared constants for the WAN clock mode configuration block
// Assumes: APB register indices are scaled by four into byte addresses
// Notes:   Reset values of command registers are all zero
package wcm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_MODE    = 3'h0; // mode_select_loop1_enable
    localparam logic [2:0] IDX_REFMUL  = 3'h1; // ref_multiplier_loop2_enable
    localparam logic [2:0] IDX_OUT1    = 3'h2; // first_output_multiplier
    localparam logic [2:0] IDX_OUT2    = 3'h3; // second_output_multiplier
    localparam logic [2:0] IDX_OUTEN   = 3'h4; // output_enables_lock_select
    localparam logic [2:0] IDX_IRQSTAT = 3'h5; // Sticky event flags, write one to clear
    localparam logic [2:0] IDX_IRQMASK = 3'h6; // Event mask, same layout
    localparam logic [2:0] IDX_STATUS  = 3'h7; // Live state, read only

    localparam int REG_W  = 5;
    localparam int EVT_W  = 3;
    localparam logic [4:0] CMD_RESET = 5'h00;

    // Field positions
    localparam int LOOP_EN_BIT   = 0;  // Loop enable in mode and ref-multiplier registers
    localparam int FRAME_EN_BIT  = 4;
    localparam int FIRST_CLOCK_OUTPUT_EN_BIT   = 3;
    localparam int SECOND_CLOCK_OUTPUT_EN_BIT   = 2;
    localparam int LOCK_SEL_HI   = 1;
    localparam int LOCK_SEL_LO   = 0;

    // Event bits
    localparam int EVT_LOCK_GAIN = 0;
    localparam int EVT_LOCK_LOSS = 1;
    localparam int EVT_RSVD_MODE = 2;

    // Lock indicator selections
    localparam logic [1:0] LOCK_ALL   = 2'h0;
    localparam logic [1:0] LOCK_LOOP2 = 2'h1;
    localparam logic [1:0] LOCK_LOOP1 = 2'h2;
    localparam logic [1:0] LOCK_OFF   = 2'h3;

    // Mode codes written to bits 4..1 of the mode register
    localparam logic [3:0] MC_F_T1_5656 = 4'h0;
    localparam logic [3:0] MC_F_T1_5664 = 4'h1;
    localparam logic [3:0] MC_F_T1_6464 = 4'h2;
    localparam logic [3:0] MC_R_56K     = 4'h3;
    localparam logic [3:0] MC_F_E1_5656 = 4'h4;
    localparam logic [3:0] MC_F_E1_5664 = 4'h5;
    localparam logic [3:0] MC_F_E1_6464 = 4'h6;
    localparam logic [3:0] MC_R_64K     = 4'h7;
    localparam logic [3:0] MC_FR_56_T1E1 = 4'h9;
    localparam logic [3:0] MC_FR_56_T1T1 = 4'hA;
    localparam logic [3:0] MC_FR_64_E1T1 = 4'hB;
    localparam logic [3:0] MC_FR_64_E1E1 = 4'hC;

    typedef enum logic [1:0] {
        WCM_FWD  = 2'b00,
        WCM_REV  = 2'b01,
        WCM_FRAC = 2'b10,
        WCM_RSVD = 2'b11
    } wcm_class_t;
endpackage : wcm_pkg

// ===== tb/wcm_loop_model.sv
// Purpose: Behavioural lock model of one synthesizer loop
// Assumes: Run level comes from the block, hold_off from the bench
// Notes:   Lock is withheld for LOCK_DLY cycles so lock edges are seen
`timescale 1ns/10ps
`default_nettype none
module wcm_loop_model #(
    parameter int LOCK_DLY = 4       // Cycles from run to lock
) (
    input  wire logic pclk,          // Clock
    input  wire logic presetn,       // Async reset, active low
    input  wire logic run,           // Loop enabled by the block
    input  wire logic hold_off,      // Bench forces loss of lock
    output logic      locked         // Lock level to the block
);
    logic [3:0] cnt_ff;
    // Any stop restarts the lock search, as a real loop would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 4'h0;
        end else if (!run || hold_off) begin
            cnt_ff <= 4'h0;
        end else if (cnt_ff != 4'(LOCK_DLY)) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
    assign locked = (cnt_ff == 4'(LOCK_DLY));
endmodule : wcm_loop_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the WAN clock mode configuration block
// Assumes: Zero-wait APB slave; outputs settle one edge after a write
// Notes:   Two lock models stand in for the loops on the far side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        l1_lock, l2_lock, hold2, master_select, err, rsv, rev, lk;
    logic        loop1_run, loop2_run, first_clock_output_out_en, second_clock_output_out_en, frame_out_en;
    logic [1:0]  mode_class;
    logic        ref_hi, loop1_hi, loop2_hi, lock_indicator, irq;
    logic [3:0]  ref_mult;
    logic [4:0]  out1_mult, out2_mult, e;
    int          fail_count, total_checks;
    // Per mode code: class, reference family, loop one and loop two families
    localparam logic [4:0] MODE_EXP [16] = '{5'h00, 5'h01, 5'h03, 5'h09, 5'h04, 5'h05,
        5'h07, 5'h0D, 5'h18, 5'h11, 5'h10, 5'h16, 5'h17, 5'h18, 5'h18, 5'h18};

    wcm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .loop1_locked(l1_lock), .loop2_locked(l2_lock),
        .master_select(master_select), .loop1_run(loop1_run), .loop2_run(loop2_run),
        .first_clock_output_out_en(first_clock_output_out_en), .second_clock_output_out_en(second_clock_output_out_en), .frame_out_en(frame_out_en),
        .mode_class(mode_class), .ref_hi(ref_hi), .loop1_hi(loop1_hi), .loop2_hi(loop2_hi),
        .ref_mult(ref_mult), .out1_mult(out1_mult), .out2_mult(out2_mult),
        .lock_indicator(lock_indicator), .irq(irq));
    wcm_loop_model m1 (.pclk(pclk), .presetn(presetn), .run(loop1_run), .hold_off(1'b0),
        .locked(l1_lock));
    wcm_loop_model m2 (.pclk(pclk), .presetn(presetn), .run(loop2_run), .hold_off(hold2),
        .locked(l2_lock));

    always #2 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One transfer; the request holds until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Registered outputs lag by an edge; three edges leave margin for the lock path
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        end_sim();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, hold2} = '0;
        master_select = 1'b1;
        fail_count    = 0;
        total_checks  = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", rd, (i == 7) ? 32'h0000_0010 : 32'h0);
        end
        $display("test reset done");
        // Upper data bits must be dropped; 31 stands for a multiplier of 32
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("readback", rd, 32'h0000_001F);
        end
        apb(1'b1, 8'h0D, 32'h0);
        chk("misaligned err", 32'(err), 32'h1);
        apb(1'b1, 8'h20, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk("out2 kept", rd, 32'h0000_001F);
        $display("test registers done");
        apb(1'b1, 8'h04, 32'h0000_000B);
        apb(1'b1, 8'h08, 32'h0000_0015);
        apb(1'b1, 8'h0C, 32'h0000_000A);
        apb(1'b1, 8'h10, 32'h0000_001C);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 8'h00, {27'h0, 4'(c), 1'b1});
            settle();
            e   = MODE_EXP[c];
            rsv = (e[4:3] == 2'b11);
            rev = (e[4:3] == 2'b01);
            chk("class", 32'(mode_class), 32'(e[4:3]));
            if (!rsv) chk("families", {ref_hi, loop1_hi, loop2_hi}, 32'(e[2:0]));
            chk("loop runs", {loop1_run, loop2_run}, rsv ? 32'h0 : 32'h3);
            chk("first_clock_output en", 32'(first_clock_output_out_en), 32'(!rsv));
            chk("second_clock_output en", 32'(second_clock_output_out_en), 32'(!rsv));
            chk("frame en", 32'(frame_out_en), 32'(!rsv));
            chk("ref mult", 32'(ref_mult), rev ? 32'h0 : 32'h5);
            chk("out mults", {out1_mult, out2_mult}, rev ? 32'h0 : 32'h0000_02AA);
        end
        $display("test modes done");
        apb(1'b1, 8'h00, 32'h0000_0006);
        settle();
        chk("first_clock_output off", 32'(first_clock_output_out_en), 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h14, 32'h0000_001F);
        repeat (8) @(posedge pclk);
        for (int h = 0; h < 2; h++) begin
            hold2 <= h[0];
            for (int s = 0; s < 4; s++) begin
                apb(1'b1, 8'h10, 32'h0000_001C | 32'(s));
                settle();
                lk = (s == 2) || (s < 2 && h == 0);
                chk("lock select", 32'(lock_indicator), 32'(lk));
            end
        end
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h10, 32'h0000_001C);
        settle();
        chk("lock one loop", 32'(lock_indicator), 32'h1);
        chk("second_clock_output off", 32'(second_clock_output_out_en), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("lock events", rd & 32'h0000_0003, 32'h0000_0003);
        $display("test lock done");
        apb(1'b1, 8'h14, 32'h0000_001F);
        apb(1'b1, 8'h18, 32'h0000_0004);
        apb(1'b1, 8'h00, 32'h0000_001F);
        settle();
        chk("irq set", 32'(irq), 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk("status", rd & 32'h0000_0011, 32'h0000_0011);
        apb(1'b1, 8'h14, 32'h0000_0004);
        settle();
        chk("irq clear", 32'(irq), 32'h0);
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_001F);
        settle();
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'b1, 8'h18, 32'h0000_0004);
        settle();
        chk("irq unmasked", 32'(irq), 32'h1);
        $display("test interrupt done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
